// ### src/lag_block_pkg.sv
// constants, register map and types of the on/off lag block
// assumes a 40 MHz system clock and a plain address/strobe register port
//
// What this block does
// - on delay holds output low until elapsed
// - output stays high while input stays high
// - without off delay, output falls with input
// - off delay holds output high until elapsed
// - on and off delays enable independently
// - clear forces output low, aborts intervals
// - clear beats input when both high
// - clear zeroes both elapsed counters
// - time base 10 ms, 100 ms or 1 s
// - on preset range 0 to 32767
// - off preset range 0 to 32767
// - presets and elapsed counts readable outside
package lag_block_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ON_PRESET = 8'h04;
   localparam logic [7:0] ADDR_OFF_PRESET = 8'h08;
   localparam logic [7:0] ADDR_ON_ELAPSED = 8'h0C;
   localparam logic [7:0] ADDR_OFF_ELAPSED = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // ****************************************************************
   // fields and reset values
   // ****************************************************************
   localparam int CTRL_ON_EN_BIT = 0;
   localparam int CTRL_OFF_EN_BIT = 1;
   localparam int CTRL_BASE_LSB = 2;
   localparam int CTRL_BASE_MSB = 3;
   localparam int STAT_OUT_BIT = 0;
   localparam int STAT_STATE_LSB = 1;
   localparam int STAT_STATE_MSB = 2;
   localparam int STAT_SIG_BIT = 3;
   localparam int PRESET_W = 15;
   localparam logic [14:0] PRESET_RST = 15'h0000;
   localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int BASE_10MS_NS = 10000000;
   localparam int CYC_PER_10MS = BASE_10MS_NS / CLK_PERIOD_NS;
   localparam logic [3:0] DECADE_LAST = 4'h9;

   typedef enum logic [1:0] {
      BASE_10MS = 2'h0,
      BASE_100MS = 2'h1,
      BASE_1S = 2'h2,
      BASE_1S_ALT = 2'h3
   } base_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ON_WAIT = 2'h1,
      ST_ACTIVE = 2'h2,
      ST_OFF_WAIT = 2'h3
   } lag_state_t;

endpackage : lag_block_pkg

// ### src/base_tick_gen.sv
// time base tick generator: one-cycle pulse per selected unit
// assumes the same system clock as the lag block
`timescale 1ns/100ps
`default_nettype none
module base_tick_gen
   import lag_block_pkg::*;
#(
   parameter int unsigned CYC_PER_BASE = CYC_PER_10MS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic restart_i,
   input wire base_t base_i,
   output logic tick_o
);

   logic [31:0] pre_q;
   logic [3:0] dec100_q;
   logic [3:0] dec1s_q;
   logic tick10;
   logic tick100;
   logic tick1s;

   // ****************************************************************
   // prescaler and decades
   // ****************************************************************
   assign tick10 = (pre_q == 32'(CYC_PER_BASE - 1));
   assign tick100 = tick10 && (dec100_q == DECADE_LAST);
   assign tick1s = tick100 && (dec1s_q == DECADE_LAST);

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || restart_i || tick10) begin
         pre_q <= 32'h0000_0000;
      end else begin
         pre_q <= pre_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || restart_i || tick100) begin
         dec100_q <= 4'h0;
         dec1s_q <= (!nrst_i || restart_i || tick1s) ? 4'h0 : dec1s_q + 4'h1;
      end else if (tick10) begin
         dec100_q <= dec100_q + 4'h1;
      end
   end

   always_comb begin
      unique case (base_i)
         BASE_10MS: tick_o = tick10;
         BASE_100MS: tick_o = tick100;
         BASE_1S, BASE_1S_ALT: tick_o = tick1s;
      endcase
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   restart_quiet_a: assert property (restart_i |=> !tick_o)
      else $error("tick follows restart too soon");

endmodule : base_tick_gen
`default_nettype wire

// ### src/lag_counter.sv
// elapsed-time counter of one delay interval, saturating at preset width
// assumes start, count enable and preset come from the same clock
`timescale 1ns/100ps
`default_nettype none
module lag_counter
   import lag_block_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic zero_i,
   input wire logic step_i,
   input wire logic [14:0] preset_i,
   output logic [14:0] count_o,
   output logic done_o
);

   logic [14:0] count_q;

   // ****************************************************************
   // counter
   // ****************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || zero_i) begin
         count_q <= PRESET_RST;
      end else if (step_i && (count_q != 15'h7FFF)) begin
         count_q <= count_q + 15'h0001;
      end
   end

   assign count_o = count_q;
   assign done_o = (count_q >= preset_i);

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   count_hold_a: assert property (!zero_i && !step_i |=> $stable(count_q))
      else $error("elapsed count moved without a tick");

   count_zero_a: assert property (zero_i |=> count_q == 15'h0000)
      else $error("elapsed count not zeroed");

endmodule : lag_counter
`default_nettype wire

// ### src/lag_block.sv
// on/off lag block: input to output with optional on and off delays
// assumes sig_i and clear_i come from logic on clk_sys_i
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module lag_block
   import lag_block_pkg::*;
#(
   parameter int unsigned CYC_PER_BASE = CYC_PER_10MS
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic sig_i,
   input wire logic clear_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic out_o,
   output logic [14:0] on_preset_o,
   output logic [14:0] on_elapsed_o,
   output logic [14:0] off_preset_o,
   output logic [14:0] off_elapsed_o
);

   // ****************************************************************
   // declarations
   // ****************************************************************
   logic on_en_q;
   logic off_en_q;
   base_t base_q;
   logic [14:0] on_preset_q;
   logic [14:0] off_preset_q;
   logic [31:0] rdata_q;
   logic out_q;
   lag_state_t state_q;
   lag_state_t state_d;
   logic on_start;
   logic off_start;
   logic on_used;
   logic off_used;
   logic tick;
   logic on_done;
   logic off_done;
   logic on_step;
   logic off_step;
   logic [14:0] on_count;
   logic [14:0] off_count;

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         on_en_q <= 1'b0;
         off_en_q <= 1'b0;
         base_q <= BASE_10MS;
      end else if (wr_i && (addr_i == ADDR_CTRL)) begin
         on_en_q <= wdata_i[CTRL_ON_EN_BIT];
         off_en_q <= wdata_i[CTRL_OFF_EN_BIT];
         base_q <= base_t'(wdata_i[CTRL_BASE_MSB:CTRL_BASE_LSB]);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         on_preset_q <= PRESET_RST;
      end else if (wr_i && (addr_i == ADDR_ON_PRESET)) begin
         on_preset_q <= wdata_i[PRESET_W-1:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         off_preset_q <= PRESET_RST;
      end else if (wr_i && (addr_i == ADDR_OFF_PRESET)) begin
         off_preset_q <= wdata_i[PRESET_W-1:0];
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         rdata_q <= RDATA_NONE;
      end else if (rd_i) begin
         unique case (addr_i)
            ADDR_CTRL: rdata_q <= {28'h0000000, base_q, off_en_q, on_en_q};
            ADDR_ON_PRESET: rdata_q <= {17'h00000, on_preset_q};
            ADDR_OFF_PRESET: rdata_q <= {17'h00000, off_preset_q};
            ADDR_ON_ELAPSED: rdata_q <= {17'h00000, on_count};
            ADDR_OFF_ELAPSED: rdata_q <= {17'h00000, off_count};
            ADDR_STATUS: rdata_q <= {28'h0000000, sig_i, state_q, out_q};
            default: rdata_q <= RDATA_NONE;
         endcase
      end else begin
         rdata_q <= RDATA_NONE;
      end
   end

   // ****************************************************************
   // time base and elapsed counters
   // ****************************************************************
   base_tick_gen #(
      .CYC_PER_BASE(CYC_PER_BASE)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .restart_i(on_start || off_start || clear_i),
      .base_i(base_q),
      .tick_o(tick)
   );

   assign on_step = (state_q == ST_ON_WAIT) && tick && sig_i && !clear_i;
   assign off_step = (state_q == ST_OFF_WAIT) && tick && !sig_i && !clear_i;

   lag_counter u_on_cnt (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .zero_i(clear_i || on_start),
      .step_i(on_step),
      .preset_i(on_preset_q),
      .count_o(on_count),
      .done_o(on_done)
   );

   lag_counter u_off_cnt (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .zero_i(clear_i || off_start),
      .step_i(off_step),
      .preset_i(off_preset_q),
      .count_o(off_count),
      .done_o(off_done)
   );

   // ****************************************************************
   // sequencer
   // ****************************************************************
   assign on_used = on_en_q && (on_preset_q != PRESET_RST);
   assign off_used = off_en_q && (off_preset_q != PRESET_RST);

   always_comb begin
      state_d = state_q;
      on_start = 1'b0;
      off_start = 1'b0;
      if (clear_i) begin
         state_d = ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (sig_i) begin
                  if (on_used) begin
                     state_d = ST_ON_WAIT;
                     on_start = 1'b1;
                  end else begin
                     state_d = ST_ACTIVE;
                  end
               end
            end
            ST_ON_WAIT: begin
               if (!sig_i) begin
                  state_d = ST_IDLE;
               end else if (on_done) begin
                  state_d = ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               if (!sig_i) begin
                  if (off_used) begin
                     state_d = ST_OFF_WAIT;
                     off_start = 1'b1;
                  end else begin
                     state_d = ST_IDLE;
                  end
               end
            end
            ST_OFF_WAIT: begin
               if (sig_i) begin
                  state_d = ST_ACTIVE;
               end else if (off_done) begin
                  state_d = ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         out_q <= 1'b0;
      end else begin
         out_q <= (state_d == ST_ACTIVE) || (state_d == ST_OFF_WAIT);
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign out_o = out_q;
   assign rdata_o = rdata_q;
   assign on_preset_o = on_preset_q;
   assign off_preset_o = off_preset_q;
   assign on_elapsed_o = on_count;
   assign off_elapsed_o = off_count;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);

   on_hold_a: assert property (
      state_q == ST_IDLE && sig_i && !clear_i && on_used |=> !out_o [*2])
      else $error("output rose before on delay");

   on_done_a: assert property (
      state_q == ST_ON_WAIT && sig_i && !clear_i && on_count >= on_preset_q |=> out_o)
      else $error("output missing after on delay");

   out_stays_a: assert property (
      state_q == ST_ACTIVE && sig_i && !clear_i |=> out_o && state_q == ST_ACTIVE)
      else $error("output dropped while input high");

   fall_direct_a: assert property (
      state_q == ST_ACTIVE && !sig_i && !clear_i && !off_used |=> !out_o)
      else $error("output late after input fall");

   off_hold_a: assert property (
      state_q == ST_ACTIVE && !sig_i && !clear_i && off_used
      |=> out_o && state_q == ST_OFF_WAIT && off_count == 15'h0000)
      else $error("off delay not started");

   clear_wins_a: assert property (
      clear_i |=> !out_o && state_q == ST_IDLE)
      else $error("clear did not force output low");

   clear_zero_a: assert property (
      clear_i |=> on_elapsed_o == 15'h0000 && off_elapsed_o == 15'h0000)
      else $error("clear left an elapsed count");

   zero_pass_a: assert property (
      state_q == ST_IDLE && sig_i && !clear_i && !on_used |=> out_o)
      else $error("zero on delay did not pass");

   restart_on_a: assert property (
      state_q == ST_OFF_WAIT && sig_i && !clear_i |=> out_o && state_q == ST_ACTIVE)
      else $error("input return did not abandon off delay");

   preset_rd_a: assert property (
      wr_i && addr_i == ADDR_ON_PRESET |=> on_preset_o == $past(wdata_i[14:0]))
      else $error("on preset not visible");

   // ****************************************************************
   // interval and register checks
   // ****************************************************************
   on_start_a: assert property (
      state_q == ST_IDLE && sig_i && !clear_i && on_used
      |=> state_q == ST_ON_WAIT && on_elapsed_o == 15'h0000)
      else $error("on delay not started");

   on_wait_low_a: assert property (
      state_q == ST_ON_WAIT && on_count < on_preset_q |=> !out_o)
      else $error("output rose inside on delay");

   on_abandon_a: assert property (
      state_q == ST_ON_WAIT && !sig_i |=> !out_o && state_q == ST_IDLE)
      else $error("input fall did not abandon on delay");

   idle_low_a: assert property (
      state_q == ST_IDLE && !sig_i |=> !out_o)
      else $error("output rose without input");

   off_wait_hold_a: assert property (
      state_q == ST_OFF_WAIT && !sig_i && !clear_i && off_count < off_preset_q
      |=> out_o && state_q == ST_OFF_WAIT)
      else $error("output fell inside off delay");

   off_done_a: assert property (
      state_q == ST_OFF_WAIT && !sig_i && !clear_i && off_count >= off_preset_q
      |=> !out_o && state_q == ST_IDLE)
      else $error("output still high after off delay");

   clear_abort_a: assert property (
      clear_i && state_q != ST_IDLE |=> !out_o && state_q == ST_IDLE)
      else $error("clear did not abort interval");

   clear_tick_a: assert property (
      clear_i |=> !tick)
      else $error("time base not restarted by clear");

   ctrl_en_a: assert property (
      wr_i && addr_i == ADDR_CTRL
      |=> on_en_q == $past(wdata_i[CTRL_ON_EN_BIT]) && off_en_q == $past(wdata_i[CTRL_OFF_EN_BIT]))
      else $error("delay enables not written");

   ctrl_base_a: assert property (
      wr_i && addr_i == ADDR_CTRL |=> base_q == $past(wdata_i[CTRL_BASE_MSB:CTRL_BASE_LSB]))
      else $error("time base not written");

   off_preset_a: assert property (
      wr_i && addr_i == ADDR_OFF_PRESET |=> off_preset_o == $past(wdata_i[14:0]))
      else $error("off preset not visible");

   tick_gap_a: assert property (
      tick |=> !tick)
      else $error("base tick longer than one cycle");

   on_step_a: assert property (
      on_step && on_count != 15'h7FFF |=> on_count == $past(on_count) + 15'h0001)
      else $error("on count missed a tick");

   off_step_a: assert property (
      off_step && off_count != 15'h7FFF |=> off_count == $past(off_count) + 15'h0001)
      else $error("off count missed a tick");

   rd_idle_a: assert property (
      !rd_i |=> rdata_o == RDATA_NONE)
      else $error("read data outside read cycle");

   rd_ctrl_a: assert property (
      rd_i && addr_i == ADDR_CTRL
      |=> rdata_o[CTRL_ON_EN_BIT] == $past(on_en_q) && rdata_o[CTRL_OFF_EN_BIT] == $past(off_en_q))
      else $error("control read back wrong");

   rd_on_preset_a: assert property (
      rd_i && addr_i == ADDR_ON_PRESET |=> rdata_o == {17'h00000, $past(on_preset_o)})
      else $error("on preset read back wrong");

   rd_elapsed_a: assert property (
      rd_i && addr_i == ADDR_ON_ELAPSED |=> rdata_o == {17'h00000, $past(on_elapsed_o)})
      else $error("on elapsed read back wrong");

   rd_off_elapsed_a: assert property (
      rd_i && addr_i == ADDR_OFF_ELAPSED |=> rdata_o == {17'h00000, $past(off_elapsed_o)})
      else $error("off elapsed read back wrong");

   rd_status_a: assert property (
      rd_i && addr_i == ADDR_STATUS
      |=> rdata_o[STAT_OUT_BIT] == $past(out_o) && rdata_o[STAT_SIG_BIT] == $past(sig_i))
      else $error("status read back wrong");

endmodule : lag_block
`default_nettype wire

// ### testbench/logic_driver.sv
// partner model: upstream logic that drives the lag block input and clear
// assumes the bench calls apply_levels from its main sequence
`timescale 1ns/100ps
`default_nettype none
module logic_driver (
   input wire logic clk_sys_i,
   output logic sig_o,
   output logic clear_o
);
   // ***********************************************
   // levels
   // ***********************************************
   initial begin
      sig_o = 1'b0;
      clear_o = 1'b0;
   end

   // levels change just after an edge; delays used are whole units
   task automatic apply_levels(input logic s, input logic c);
      @(posedge clk_sys_i);
      sig_o <= s;
      clear_o <= c;
   endtask : apply_levels
endmodule : logic_driver
`default_nettype wire

// ### testbench/lag_block_bench.sv
// bench for the lag block: register tasks and timed input sequences
// assumes the block is built with a short time base count
`timescale 1ns/100ps
`default_nettype none
module lag_block_bench;
   import lag_block_pkg::*;
   localparam int unsigned CPB = 4;
   logic clk_sys_i, nrst_i, sig_i, clear_i, wr_i, rd_i, out_o;
   logic [7:0] addr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [14:0] on_preset_o, on_elapsed_o, off_preset_o, off_elapsed_o;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int u;

   // ***********************************************
   // instances
   // ***********************************************
   lag_block #(.CYC_PER_BASE(CPB)) u_lag_block (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sig_i(sig_i), .clear_i(clear_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .out_o(out_o), .on_preset_o(on_preset_o),
      .on_elapsed_o(on_elapsed_o), .off_preset_o(off_preset_o),
      .off_elapsed_o(off_elapsed_o)
   );
   logic_driver u_logic_driver (.clk_sys_i(clk_sys_i), .sig_o(sig_i), .clear_o(clear_i));

   // ***********************************************
   // clock, timeout, tasks
   // ***********************************************
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1;
      chk("rdata_o", rdata_o, exp);
   endtask : rd

   task automatic drive(input logic s, input logic c);
      u_logic_driver.apply_levels(s, c);
   endtask : drive

   // out_o takes v at the m-th edge after the levels change, not before
   task automatic wait_out(input int m, input logic v);
      repeat (m - 1) @(posedge clk_sys_i);
      #1;
      chk("out_o early", {31'h0, out_o}, {31'h0, ~v});
      @(posedge clk_sys_i);
      #1;
      chk("out_o", {31'h0, out_o}, {31'h0, v});
   endtask : wait_out

   task automatic hold_out(input int m, input logic v);
      repeat (m) @(posedge clk_sys_i);
      #1;
      chk("out_o held", {31'h0, out_o}, {31'h0, v});
   endtask : hold_out

   // ***********************************************
   // sequence
   // ***********************************************
   initial begin
      nrst_i = 1'b0;
      addr_i = 8'h00;
      wdata_i = 32'h0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      repeat (16) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      #1;
      chk("on_elapsed_o", {17'h0, on_elapsed_o}, 32'h0);
      rd(ADDR_CTRL, 32'h0);
      rd(8'h18, RDATA_NONE);
      rd(ADDR_STATUS, 32'h0);
      wr(ADDR_ON_PRESET, 32'hFFFF_FFFF);
      rd(ADDR_ON_PRESET, 32'h0000_7FFF);
      chk("on_preset_o", {17'h0, on_preset_o}, 32'h0000_7FFF);
      wr(ADDR_OFF_PRESET, 32'h0000_7FFF);
      rd(ADDR_OFF_PRESET, 32'h0000_7FFF);
      chk("off_preset_o", {17'h0, off_preset_o}, 32'h0000_7FFF);
      wr(ADDR_ON_PRESET, 32'h0);
      wr(ADDR_OFF_PRESET, 32'h0);
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_CTRL, 32'(i * 3));
         drive(1'b1, 1'b0);
         wait_out(1, 1'b1);
         drive(1'b0, 1'b0);
         wait_out(1, 1'b0);
      end
      wr(ADDR_ON_PRESET, 32'h1);
      for (int b = 0; b < 4; b++) begin
         u = (b == 0) ? 1 : (b == 1) ? 10 : 100;
         wr(ADDR_CTRL, 32'(b * 4 + 1));
         drive(1'b1, 1'b0);
         wait_out(u * CPB + 2, 1'b1);
         drive(1'b0, 1'b0);
         wait_out(1, 1'b0);
      end
      wr(ADDR_ON_PRESET, 32'h2);
      wr(ADDR_CTRL, 32'h1);
      drive(1'b1, 1'b0);
      rd(ADDR_STATUS, 32'h0000_000A);
      repeat (3) @(posedge clk_sys_i);
      drive(1'b0, 1'b0);
      hold_out(12, 1'b0);
      drive(1'b1, 1'b0);
      wait_out(2 * CPB + 2, 1'b1);
      hold_out(20, 1'b1);
      chk("on_elapsed_o", {17'h0, on_elapsed_o}, 32'h2);
      rd(ADDR_ON_ELAPSED, 32'h2);
      rd(ADDR_STATUS, 32'h0000_000D);
      drive(1'b0, 1'b0);
      wait_out(1, 1'b0);
      wr(ADDR_OFF_PRESET, 32'h3);
      wr(ADDR_CTRL, 32'h2);
      drive(1'b1, 1'b0);
      wait_out(1, 1'b1);
      drive(1'b0, 1'b0);
      rd(ADDR_STATUS, 32'h0000_0007);
      repeat (3) @(posedge clk_sys_i);
      drive(1'b1, 1'b0);
      hold_out(20, 1'b1);
      drive(1'b0, 1'b0);
      wait_out(3 * CPB + 2, 1'b0);
      rd(ADDR_OFF_ELAPSED, 32'h3);
      wr(ADDR_CTRL, 32'h3);
      drive(1'b1, 1'b0);
      wait_out(2 * CPB + 2, 1'b1);
      drive(1'b0, 1'b0);
      wait_out(3 * CPB + 2, 1'b0);
      drive(1'b1, 1'b0);
      repeat (6) @(posedge clk_sys_i);
      drive(1'b1, 1'b1);
      hold_out(20, 1'b0);
      chk("on_elapsed_o", {17'h0, on_elapsed_o}, 32'h0);
      drive(1'b0, 1'b0);
      drive(1'b1, 1'b0);
      wait_out(2 * CPB + 2, 1'b1);
      drive(1'b1, 1'b1);
      wait_out(1, 1'b0);
      chk("off_elapsed_o", {17'h0, off_elapsed_o}, 32'h0);
      chk("on_elapsed_o", {17'h0, on_elapsed_o}, 32'h0);
      drive(1'b0, 1'b0);
      hold_out(20, 1'b0);
      give_verdict();
   end
endmodule : lag_block_bench
`default_nettype wire
